// ### bench/asfw_drive_model.sv
`timescale 1ns/1ps
module asfw_drive_model (
  input wire logic [21:0] i_cmd, // pin levels wanted by the bench
  output logic [21:0] o_pins = 22'h00_0000 // drive and sensor pin levels
);
  // real pins move with no regard to the clock, so the skew tests the input filter
  always @(i_cmd)
    o_pins <= #7 i_cmd;
endmodule

// ### bench/asfw_status_words_monitor.sv
`timescale 1ns/1ps
module asfw_status_words_monitor
  import asfw_pkg::*;
#(
  parameter int unsigned AXES = 2
)(
  input wire logic i_clock, // clock
  input wire logic i_rst_n, // reset
  input wire logic [AXES-1:0] i_sensor_err, // sensor fault
  input wire logic [AXES-1:0] i_servo_err, // servo alarm
  input wire logic [AXES-1:0] i_exec_err, // command error
  input wire logic [AXES-1:0] i_axis_warn, // warning
  input wire logic [AXES-1:0] i_axis_err, // axis error
  input wire logic [3*AXES-1:0] i_zone, // zones
  input wire logic [7:0] i_araddr, // read addr
  input wire logic i_arvalid, // ar valid
  input wire logic o_arready, // ar ready
  input wire logic [31:0] o_rdata, // read data
  input wire logic o_rvalid, // r valid
  input wire logic i_rready, // r ready
  input wire logic i_awvalid, // aw valid
  input wire logic o_awready, // aw ready
  input wire logic i_wvalid, // w valid
  input wire logic o_wready, // w ready
  input wire logic o_bvalid, // b valid
  input wire logic i_bready // b ready
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] ra_q;
  wire [7:0] cs1 = {i_zone[2:0], i_axis_err[0], i_axis_warn[0], i_exec_err[0], i_servo_err[0],
    i_sensor_err[0]};
  // keep the read address so each answer can be tied to its word
  always_ff @(posedge i_clock)
  begin
    if (i_arvalid && o_arready)
      ra_q <= i_araddr;
  end
  a_read_answered:
    assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read not answered");
  a_read_ends:
    assert property (o_rvalid && i_rready |=> !o_rvalid) else $error("rvalid stuck");
  a_ar_blocked:
    assert property (o_rvalid |-> !o_arready) else $error("ar open during r");
  a_upper_zero:
    assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000) else $error("upper half set");
  a_write_answered:
    assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
    else $error("write not answered");
  a_write_ends:
    assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("bvalid stuck");
  a_aw_blocked:
    assert property (o_bvalid |-> !o_awready && !o_wready) else $error("aw open during b");
  a_ctrl_flags:
    assert property ($rose(o_rvalid) && ra_q == ASFW_AXIS1_CTRL_ADDR
      |-> o_rdata[15:8] == $past(cs1, 2)) else $error("control flags wrong");
endmodule
bind asfw_status_words asfw_status_words_monitor #(.AXES(AXES)) asfw_status_words_monitor_inst (
  .i_clock, .i_rst_n, .i_sensor_err, .i_servo_err, .i_exec_err, .i_axis_warn, .i_axis_err,
  .i_zone, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .i_awvalid,
  .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready);

// ### bench/asfw_status_words_tb.sv
`timescale 1ns/1ps
module asfw_status_words_tb;
  import asfw_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [25:0] sc = '0;
  logic [21:0] pc = '0;
  wire [21:0] pin;
  logic [7:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0] i_wdata = '0;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  wire [2:0] hs = {o_bvalid, o_rvalid, o_arready};
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] wa[6] = '{8'h14, 8'h18, 8'h48, 8'h4C, 8'h1C, 8'hFC};
  int n_errors = 0;
  int cmp_count = 0;
  always #12.5 i_clock = ~i_clock;
  asfw_drive_model asfw_drive_model_inst (.i_cmd(pc), .o_pins(pin));
  asfw_status_words asfw_status_words_inst (.i_clock, .i_rst_n, .i_sensor_err(sc[1:0]),
    .i_servo_err(sc[3:2]), .i_exec_err(sc[5:4]), .i_axis_warn(sc[7:6]), .i_axis_err(sc[9:8]),
    .i_zone(sc[15:10]), .i_in_pos(sc[17:16]), .i_alm_rst_out(sc[19:18]),
    .i_dev_rst_out(sc[21:20]), .i_fwd_trq_out(sc[23:22]), .i_rev_trq_out(sc[25:24]),
    .i_servo_on(pin[1:0]), .i_main_pwr(pin[3:2]), .i_drv_warn(pin[5:4]),
    .i_servo_rdy(pin[7:6]), .i_fwd_lim(pin[9:8]), .i_rev_lim(pin[11:10]),
    .i_home_prox(pin[13:12]), .i_home(pin[15:14]), .i_ext_int(pin[17:16]),
    .i_estop(pin[19:18]), .i_drv_alm(pin[21:20]), .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
  // expected word of axis n, built from the levels the bench is holding
  function automatic logic [33:0] ex(input logic [7:0] a);
    int n;
    n = a[6];
    if (a == 8'h14 || a == 8'h48)
      return {ASFW_RESP_OKAY, 16'h0000, sc[10+3*n+:3], sc[8+n], sc[6+n], sc[4+n], sc[2+n],
        sc[n], 8'h00};
    if (a == 8'h18 || a == 8'h4C)
      return {ASFW_RESP_OKAY, 16'h0000, pc[20+n], sc[16+n], pc[18+n], pc[16+n], pc[14+n],
        pc[12+n], pc[10+n], pc[8+n], pc[6+n], pc[4+n], pc[2+n], sc[24+n], sc[22+n],
        sc[20+n], sc[18+n], pc[n]};
    return {ASFW_RESP_SLVERR, 32'h0000_0000};
  endfunction
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 50)
    begin
      n_errors++;
      final_report();
    end
  endtask
  // a hung handshake is cut short after fifty cycles
  task automatic wt(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (!hs[k] && n < 50);
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    rq.push_back(ex(a));
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    wt(0);
    i_arvalid <= 1'b0;
    wt(1);
    // rready stays up between reads, so back-to-back calls never assign it twice in one step
  endtask
  task automatic wr(input logic [7:0] a);
    logic [33:0] e;
    int n;
    e = ex(a);
    bq.push_back(e[33:32]);
    i_awaddr <= a;
    i_wdata <= $urandom;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end
    while ((i_awvalid && !o_awready || i_wvalid && !o_wready) && n < 50);
    tmo(n);
    wt(2);
    i_bready <= 1'b0;
  endtask
  // let the pin filter settle, then read every word and two unmapped places
  task automatic sweep();
    repeat (8) @(posedge i_clock);
    foreach (wa[i])
      rd(wa[i]);
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // answers are matched in order against the oldest note
  always @(posedge i_clock)
  begin
    if (o_rvalid && i_rready)
      chk({o_rresp, o_rdata}, rq.pop_front());
    if (o_bvalid && i_bready)
      chk({32'h0000_0000, o_bresp}, {32'h0000_0000, bq.pop_front()});
  end
  initial
  begin
    void'($urandom(77170));
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    // one source at a time shows each flag lands on its own bit only
    for (int k = 0; k < 48; k++)
    begin
      sc <= (k < 26) ? 26'h1 << k : '0;
      pc <= (k > 25) ? 22'h1 << (k - 26) : '0;
      sweep();
    end
    repeat (20)
    begin
      sc <= 26'($urandom);
      pc <= 22'($urandom);
      sweep();
      // a write must be answered yet leave the word as it was
      foreach (wa[i])
      begin
        wr(wa[i]);
        rd(wa[i]);
      end
    end
    final_report();
  end
endmodule

// ### hdl/asfw_pkg.sv
package asfw_pkg;
  // word indices as printed; byte address is four times the index
  localparam int unsigned ASFW_AXIS1_CTRL_IDX = 5;
  localparam int unsigned ASFW_AXIS1_IO_IDX = 6;
  localparam int unsigned ASFW_AXIS2_CTRL_IDX = 18;
  localparam int unsigned ASFW_AXIS2_IO_IDX = 19;
  localparam logic [7:0] ASFW_AXIS1_CTRL_ADDR = 8'h14;
  localparam logic [7:0] ASFW_AXIS1_IO_ADDR = 8'h18;
  localparam logic [7:0] ASFW_AXIS2_CTRL_ADDR = 8'h48;
  localparam logic [7:0] ASFW_AXIS2_IO_ADDR = 8'h4C;
  // control status field positions
  localparam int unsigned ASFW_CS_SENSOR_ERR = 8;
  localparam int unsigned ASFW_CS_SERVO_ERR = 9;
  localparam int unsigned ASFW_CS_EXEC_ERR = 10;
  localparam int unsigned ASFW_CS_AXIS_WARN = 11;
  localparam int unsigned ASFW_CS_AXIS_ERR = 12;
  localparam int unsigned ASFW_CS_ZONE0 = 13;
  // io status field positions
  localparam int unsigned ASFW_IO_SERVO_ON = 0;
  localparam int unsigned ASFW_IO_ALM_RST = 1;
  localparam int unsigned ASFW_IO_DEV_RST = 2;
  localparam int unsigned ASFW_IO_FWD_TRQ = 3;
  localparam int unsigned ASFW_IO_REV_TRQ = 4;
  localparam int unsigned ASFW_IO_MAIN_PWR = 5;
  localparam int unsigned ASFW_IO_DRV_WARN = 6;
  localparam int unsigned ASFW_IO_SERVO_RDY = 7;
  localparam int unsigned ASFW_IO_FWD_LIM = 8;
  localparam int unsigned ASFW_IO_REV_LIM = 9;
  localparam int unsigned ASFW_IO_HOME_PROX = 10;
  localparam int unsigned ASFW_IO_HOME = 11;
  localparam int unsigned ASFW_IO_EXT_INT = 12;
  localparam int unsigned ASFW_IO_ESTOP = 13;
  localparam int unsigned ASFW_IO_IN_POS = 14;
  localparam int unsigned ASFW_IO_DRV_ALM = 15;
  localparam logic [15:0] ASFW_WORD_RESET = 16'h0000;
  localparam logic [1:0] ASFW_RESP_OKAY = 2'b00;
  localparam logic [1:0] ASFW_RESP_SLVERR = 2'b10;
endpackage

// ### hdl/asfw_status_words.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module asfw_status_words
  import asfw_pkg::*;
#(
  parameter int unsigned AXES = 2
)(
  input wire logic i_clock, // 40 mhz system clock
  input wire logic i_rst_n, // synchronous reset, active low
  // per-axis sources, bit n (zone bits 3n..3n+2) belongs to axis n
  input wire logic [AXES-1:0] i_sensor_err, // sensor fault event/level
  input wire logic [AXES-1:0] i_servo_err, // servo alarm error
  input wire logic [AXES-1:0] i_exec_err, // command execution error
  input wire logic [AXES-1:0] i_axis_warn, // memory operation warning
  input wire logic [AXES-1:0] i_axis_err, // any axis error
  input wire logic [3*AXES-1:0] i_zone, // zone 0..2 membership, 3 per axis
  input wire logic [AXES-1:0] i_in_pos, // within in-position band
  input wire logic [AXES-1:0] i_alm_rst_out, // alarm reset output active
  input wire logic [AXES-1:0] i_dev_rst_out, // deviation reset output active
  input wire logic [AXES-1:0] i_fwd_trq_out, // forward torque limit output
  input wire logic [AXES-1:0] i_rev_trq_out, // reverse torque limit output
  // per-axis pins from drive and machine (asynchronous)
  input wire logic [AXES-1:0] i_servo_on, // motor energised
  input wire logic [AXES-1:0] i_main_pwr, // main circuit powered
  input wire logic [AXES-1:0] i_drv_warn, // drive warning
  input wire logic [AXES-1:0] i_servo_rdy, // drive ready
  input wire logic [AXES-1:0] i_fwd_lim, // forward travel limit
  input wire logic [AXES-1:0] i_rev_lim, // reverse travel limit
  input wire logic [AXES-1:0] i_home_prox, // home proximity sensor
  input wire logic [AXES-1:0] i_home, // home position input
  input wire logic [AXES-1:0] i_ext_int, // external interrupt input
  input wire logic [AXES-1:0] i_estop, // emergency stop input
  input wire logic [AXES-1:0] i_drv_alm, // drive alarm input
  // axi4-lite slave
  input wire logic [7:0] i_awaddr, // write address
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [31:0] i_wdata, // write data, ignored
  input wire logic [3:0] i_wstrb, // write strobes, ignored
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  output logic [1:0] o_bresp, // write response
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  input wire logic [7:0] i_araddr, // read address
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  output logic [31:0] o_rdata, // read data
  output logic [1:0] o_rresp, // read response
  output logic o_rvalid, // read data valid
  input wire logic i_rready // read data ready
);

  // overview of the datapath:
  //   same-clock sources feed the words directly, one edge of latency;
  //   pins from the drive and the machine pass three flip-flops and an
  //   agreement filter before they reach the io word, five edges in all;
  //   the host sees both words of each axis through a small axi4-lite slave.
  //
  // limitations a user must know:
  //   error and warning flags are plain levels; whoever raises them must
  //   hold them until software has seen them, nothing here latches them;
  //   the lower byte of the control word belongs to other logic and
  //   reads as zero from this block;
  //   a pulse shorter than two clock periods on a pin may be lost, which
  //   was accepted in exchange for immunity against single-cycle glitches.
  //
  // pin order inside one axis slice of the gathered vector:
  //   0 servo on, 1 main power, 2 drive warning, 3 drive ready,
  //   4 forward limit, 5 reverse limit, 6 home proximity, 7 home,
  //   8 external interrupt, 9 emergency stop, 10 drive alarm.
  localparam int unsigned NPIN = 11;

  // pins gathered per axis so one synchroniser loop serves all of them
  logic [NPIN*AXES-1:0] pin_raw;
  logic [NPIN*AXES-1:0] pin_s1_q;
  logic [NPIN*AXES-1:0] pin_s2_q;
  logic [NPIN*AXES-1:0] pin_s3_q;
  logic [NPIN*AXES-1:0] pin_clean_q;
  logic [15:0] ctrl_word_q [AXES];
  logic [15:0] io_word_q [AXES];

  // one slice per axis; the second axis copies the layout of the first,
  // so adding axes only widens the port vectors and the address map
  // repeats every thirteen words.
  // the words are rebuilt every cycle from their sources, so no stale
  // flag can survive once the condition behind it has gone away.
  genvar g;
  generate
    for (g = 0; g < AXES; g++)
    begin : g_axis
      assign pin_raw[NPIN*g +: NPIN] = {i_drv_alm[g], i_estop[g], i_ext_int[g], i_home[g],
        i_home_prox[g], i_rev_lim[g], i_fwd_lim[g], i_servo_rdy[g], i_drv_warn[g],
        i_main_pwr[g], i_servo_on[g]};

      // control word; lower byte belongs to other logic and reads zero
      always_ff @(posedge i_clock)
      begin
        if (!i_rst_n)
          ctrl_word_q[g] <= ASFW_WORD_RESET;
        else
        begin
          ctrl_word_q[g] <= ASFW_WORD_RESET;
          ctrl_word_q[g][ASFW_CS_SENSOR_ERR] <= i_sensor_err[g];
          ctrl_word_q[g][ASFW_CS_SERVO_ERR] <= i_servo_err[g];
          ctrl_word_q[g][ASFW_CS_EXEC_ERR] <= i_exec_err[g];
          ctrl_word_q[g][ASFW_CS_AXIS_WARN] <= i_axis_warn[g];
          ctrl_word_q[g][ASFW_CS_AXIS_ERR] <= i_axis_err[g];
          ctrl_word_q[g][ASFW_CS_ZONE0 +: 3] <= i_zone[3*g +: 3];
        end
      end

      // io word; drive outputs are internal, drive inputs come filtered
      always_ff @(posedge i_clock)
      begin
        if (!i_rst_n)
          io_word_q[g] <= ASFW_WORD_RESET;
        else
        begin
          io_word_q[g][ASFW_IO_SERVO_ON] <= pin_clean_q[NPIN*g];
          io_word_q[g][ASFW_IO_ALM_RST] <= i_alm_rst_out[g];
          io_word_q[g][ASFW_IO_DEV_RST] <= i_dev_rst_out[g];
          io_word_q[g][ASFW_IO_FWD_TRQ] <= i_fwd_trq_out[g];
          io_word_q[g][ASFW_IO_REV_TRQ] <= i_rev_trq_out[g];
          io_word_q[g][ASFW_IO_MAIN_PWR] <= pin_clean_q[NPIN*g+1];
          io_word_q[g][ASFW_IO_DRV_WARN] <= pin_clean_q[NPIN*g+2];
          io_word_q[g][ASFW_IO_SERVO_RDY] <= pin_clean_q[NPIN*g+3];
          io_word_q[g][ASFW_IO_FWD_LIM] <= pin_clean_q[NPIN*g+4];
          io_word_q[g][ASFW_IO_REV_LIM] <= pin_clean_q[NPIN*g+5];
          io_word_q[g][ASFW_IO_HOME_PROX] <= pin_clean_q[NPIN*g+6];
          io_word_q[g][ASFW_IO_HOME] <= pin_clean_q[NPIN*g+7];
          io_word_q[g][ASFW_IO_EXT_INT] <= pin_clean_q[NPIN*g+8];
          io_word_q[g][ASFW_IO_ESTOP] <= pin_clean_q[NPIN*g+9];
          io_word_q[g][ASFW_IO_IN_POS] <= i_in_pos[g];
          io_word_q[g][ASFW_IO_DRV_ALM] <= pin_clean_q[NPIN*g+10];
        end
      end
    end
  endgenerate

  // the first stage may go metastable; only the second stage reads it.
  // stages two and three are compared so that a level is only believed
  // once it has stood for two consecutive samples.
  // reset clears all stages, so every pin reads inactive after reset
  // until the real level has worked its way through.
  // three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // clean level holds its old value while stages disagree
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      pin_clean_q <= '0;
    else
      pin_clean_q <= (pin_s2_q & pin_s3_q) | (pin_clean_q & (pin_s2_q | pin_s3_q));
  end

  // write handling notes:
  //   the words are read-only, so a write only needs an answer;
  //   address and data may arrive in either order or together;
  //   each half is refused after it is taken until the response is
  //   accepted, which keeps exactly one write outstanding;
  //   mapped addresses answer okay, anything else answers slverr, so
  //   software can tell a typo in the address from a harmless write;
  //   write data and strobes are never looked at.
  //
  // the response appears one cycle after both halves are held, giving
  // the decode of the stored address a full cycle of its own.
  // write channel: both halves taken in either order, then okay or error
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic aw_fire;
  logic w_fire;
  logic wr_mapped;
  assign aw_fire = i_awvalid && o_awready;
  assign w_fire = i_wvalid && o_wready;

  always_comb
  begin
    wr_mapped = 1'b0;
    for (int a = 0; a < AXES; a++)
    begin
      if (aw_addr_q == ASFW_AXIS1_CTRL_ADDR + 8'(a * 52)
          || aw_addr_q == ASFW_AXIS1_IO_ADDR + 8'(a * 52))
        wr_mapped = 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      o_bvalid <= 1'b0;
      o_bresp <= ASFW_RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (w_fire)
      begin
        w_have_q <= 1'b1;
        o_wready <= 1'b0;
      end
      // data is discarded: the words are read-only
      if (aw_have_q && w_have_q && !o_bvalid)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_mapped ? ASFW_RESP_OKAY : ASFW_RESP_SLVERR;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // read handling notes:
  //   the address is decoded combinationally in the cycle it is offered
  //   and the word is captured at the handshake edge, so the answer comes
  //   one cycle after the address is taken;
  //   arready stays low while the answer waits, one read at a time;
  //   the upper half of the data bus always reads zero;
  //   an unmapped address answers slverr with zero data;
  //   the word returned is the one that stood at the handshake edge, so
  //   a flag that changes while the answer waits is seen on the next read.
  //
  // trade-off: a registered address would ease timing but cost a cycle;
  // the map is two compares per axis, small enough to decode directly.
  // read channel: one-cycle decode, unmapped addresses answer slverr
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b0;
    for (int a = 0; a < AXES; a++)
    begin
      if (i_araddr == ASFW_AXIS1_CTRL_ADDR + 8'(a * 52))
      begin
        rd_word = {16'h0000, ctrl_word_q[a]};
        rd_hit = 1'b1;
      end
      if (i_araddr == ASFW_AXIS1_IO_ADDR + 8'(a * 52))
      begin
        rd_word = {16'h0000, io_word_q[a]};
        rd_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= ASFW_RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_hit ? ASFW_RESP_OKAY : ASFW_RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule
